// ===== verilog/dfts_pkg.sv
// Constants for the drive fault trip supervisor: map, codes, timing.
// Assumes a 100 MHz mclk and APB access with 32-bit data.
package dfts_pkg;

  // Register byte offsets
  localparam logic [7:0] DFTS_CTRL_OFF = 8'h00;
  localparam logic [7:0] DFTS_VIEW_OFF = 8'h04;
  localparam logic [7:0] DFTS_HIST_OFF = 8'h08;
  localparam logic [7:0] DFTS_LIMT_OFF = 8'h1C;
  localparam logic [7:0] DFTS_MAXF_OFF = 8'h20;
  localparam logic [7:0] DFTS_ISTA_OFF = 8'h24;
  localparam logic [7:0] DFTS_IMSK_OFF = 8'h28;
  localparam int DFTS_HIST_N = 5;

  // Field layout
  localparam int DFTS_CTRL_RST_BIT = 0;
  localparam int DFTS_VIEW_EN_BIT = 8;
  localparam int DFTS_VIEW_LAT_BIT = 9;
  localparam int DFTS_STAT_LSB = 8;

  // Fault codes, also bit index in the interrupt status
  localparam logic [3:0] DFTS_F_NONE = 4'h0;
  localparam logic [3:0] DFTS_F_SURGE = 4'h1;
  localparam logic [3:0] DFTS_F_LEAK = 4'h2;
  localparam logic [3:0] DFTS_F_DCHI = 4'h3;
  localparam logic [3:0] DFTS_F_SUST = 4'h4;
  localparam logic [3:0] DFTS_F_LINK = 4'h5;
  localparam logic [3:0] DFTS_F_HEAT = 4'h6;
  localparam logic [3:0] DFTS_F_THERM = 4'h7;
  localparam logic [3:0] DFTS_F_EXTNO = 4'h8;
  localparam logic [3:0] DFTS_F_EXTNC = 4'h9;
  localparam logic [3:0] DFTS_F_DCLO = 4'hA;
  localparam logic [3:0] DFTS_F_SHORT = 4'hB;
  localparam logic [3:0] DFTS_F_PHASE = 4'hC;
  localparam logic [3:0] DFTS_F_SPEED = 4'hD;
  localparam logic [3:0] DFTS_F_CUT = 4'hE;

  // Pin vector positions
  localparam int DFTS_P_LEAK = 0;
  localparam int DFTS_P_DCHI = 1;
  localparam int DFTS_P_DCLO = 2;
  localparam int DFTS_P_LINK = 3;
  localparam int DFTS_P_HEAT = 4;
  localparam int DFTS_P_EXTNO = 5;
  localparam int DFTS_P_EXTNC = 6;
  localparam int DFTS_P_SHORT = 7;
  localparam int DFTS_P_CUT = 8;
  localparam int DFTS_P_RSTT = 9;
  localparam int DFTS_P_PH = 10;
  localparam int DFTS_PINS = 13;
  // Idle levels: closed contact and open reset terminal read high
  localparam logic [12:0] DFTS_PIN_IDLE = 13'h0240;

  // Protection levels, percent of rated current and 0.1 Hz units
  localparam logic [9:0] DFTS_SURGE_PCT = 10'd200;
  localparam logic [9:0] DFTS_SUST_PCT = 10'd180;
  localparam logic [9:0] DFTS_OVL_PCT = 10'd150;
  localparam logic [9:0] DFTS_RATED_PCT = 10'd100;
  localparam logic [15:0] DFTS_SPEED_EXCESS_TRIP_MARGIN = 16'd200;

  // Timing
  localparam int DFTS_CLK_NS = 10;
  localparam int DFTS_TICK_NS = 1000000;
  localparam int DFTS_TICK_CYC = DFTS_TICK_NS / DFTS_CLK_NS;
  localparam int DFTS_THERM_MIN = 1;
  localparam int DFTS_THERM_MS = DFTS_THERM_MIN * 60000;
  localparam logic [23:0] DFTS_THERM_LIM = 24'(50 * DFTS_THERM_MS);
  localparam logic [15:0] DFTS_LIMT_RST = 16'd60000;
  localparam logic [15:0] DFTS_MAXF_RST = 16'd600;

endpackage

// ===== verilog/dfts_supervisor.sv
// Fault trip supervisor: latches drive protection trips, gates the
// power stage, keeps a five-deep trip history, APB registers and irq.
// Assumes same-clock measurement buses and asynchronous sense pins.
`timescale 1ns/1ps

module dfts_supervisor import dfts_pkg::*; #(
  parameter int TICK_CYC = DFTS_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DFTS_PINS-1:0] sense_pins,
  input wire logic [9:0] cur_pct,
  input wire logic [15:0] motor_freq,
  input wire logic [15:0] op_status,
  output logic pwr_en,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, change taken when 2 and 3 agree
  logic [DFTS_PINS-1:0] s1_r, s2_r, s3_r, pin_r;

  genvar gi;
  generate
    for (gi = 0; gi < DFTS_PINS; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[gi] <= DFTS_PIN_IDLE[gi];
          s2_r[gi] <= DFTS_PIN_IDLE[gi];
          s3_r[gi] <= DFTS_PIN_IDLE[gi];
          pin_r[gi] <= DFTS_PIN_IDLE[gi];
        end else begin
          s1_r[gi] <= sense_pins[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            pin_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Registers written by software
  logic [15:0] limit_ms_r;
  logic [15:0] max_freq_r;
  logic [15:0] irq_stat_r;
  logic [15:0] irq_mask_r;
  logic key_rst_r;
  logic [31:0] prdata_r;
  logic wr_acc, rd_setup, addr_ok;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= DFTS_IMSK_OFF);

  ////////////////////////////////////////////////////////////////////
  // Millisecond tick
  // Counter keeps at least one bit so a one-cycle tick still elaborates
  localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;

  assign tick = (tick_cnt_r == TICK_W'(TICK_CYC - 1));

  // Free-running divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sustained current timer
  logic [15:0] sust_ms_r;
  logic sust_hit;

  assign sust_hit = (cur_pct >= DFTS_SUST_PCT) && (sust_ms_r >= limit_ms_r);

  // Counts ms spent at or above the sustained level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sust_ms_r <= '0;
    end else if (cur_pct < DFTS_SUST_PCT) begin
      sust_ms_r <= '0;
    end else if (tick && sust_ms_r != 16'hFFFF) begin
      sust_ms_r <= sust_ms_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Motor thermal model: excess over rated heats, at or below rated cools
  logic [23:0] therm_r;
  logic [23:0] therm_add;

  assign therm_add = 24'(cur_pct - DFTS_RATED_PCT);

  // Heat sized so 150 percent for one minute reaches the limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      therm_r <= '0;
    end else if (tick) begin
      if (cur_pct > DFTS_RATED_PCT) begin
        if (therm_r < DFTS_THERM_LIM) begin
          therm_r <= therm_r + therm_add;
        end
      end else if (therm_r != '0) begin
        therm_r <= therm_r - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trip conditions, lowest code wins when several meet
  logic [15:0] cond;
  logic [3:0] new_code;
  logic trip_any;
  logic [16:0] speed_excess_trip_lim;

  assign speed_excess_trip_lim = {1'b0, max_freq_r} + {1'b0, DFTS_SPEED_EXCESS_TRIP_MARGIN};

  // Condition vector indexed by fault code
  always_comb begin
    cond = '0;
    cond[DFTS_F_SURGE] = cur_pct > DFTS_SURGE_PCT;
    cond[DFTS_F_LEAK] = pin_r[DFTS_P_LEAK];
    cond[DFTS_F_DCHI] = pin_r[DFTS_P_DCHI];
    cond[DFTS_F_SUST] = sust_hit;
    cond[DFTS_F_LINK] = pin_r[DFTS_P_LINK];
    cond[DFTS_F_HEAT] = pin_r[DFTS_P_HEAT];
    cond[DFTS_F_THERM] = therm_r >= DFTS_THERM_LIM;
    cond[DFTS_F_EXTNO] = pin_r[DFTS_P_EXTNO];
    cond[DFTS_F_EXTNC] = !pin_r[DFTS_P_EXTNC];
    cond[DFTS_F_DCLO] = pin_r[DFTS_P_DCLO];
    cond[DFTS_F_SHORT] = pin_r[DFTS_P_SHORT];
    cond[DFTS_F_PHASE] = |pin_r[DFTS_P_PH +: 3];
    cond[DFTS_F_SPEED] = {1'b0, motor_freq} > speed_excess_trip_lim;
  end

  // Priority encoder
  always_comb begin
    new_code = DFTS_F_NONE;
    for (int i = 15; i > 0; i--) begin
      if (cond[i]) begin
        new_code = 4'(i);
      end
    end
  end

  assign trip_any = (new_code != DFTS_F_NONE);

  ////////////////////////////////////////////////////////////////////
  // Fault latch and reset sources
  logic [3:0] fault_r;
  logic latched;
  logic clr_req;
  logic new_trip;
  logic cut;

  assign latched = (fault_r != DFTS_F_NONE);
  assign clr_req = key_rst_r || !pin_r[DFTS_P_RSTT];
  assign new_trip = trip_any && !latched;
  assign cut = pin_r[DFTS_P_CUT];

  // Holds the first fault until reset; power-on reset also clears
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= DFTS_F_NONE;
    end else if (clr_req) begin
      fault_r <= DFTS_F_NONE;
    end else if (new_trip) begin
      fault_r <= new_code;
    end
  end

  // Output stage gate, cut-off acts without latching
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_en <= 1'b0;
    end else begin
      pwr_en <= !trip_any && !latched && !cut && !clr_req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trip history, slot 0 newest
  logic [3:0] hist_code_r [DFTS_HIST_N];
  logic [15:0] hist_stat_r [DFTS_HIST_N];

  // Shift on each new trip, dropping the oldest
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DFTS_HIST_N; i++) begin
        hist_code_r[i] <= DFTS_F_NONE;
        hist_stat_r[i] <= '0;
      end
    end else if (new_trip && !clr_req) begin
      hist_code_r[0] <= new_code;
      hist_stat_r[0] <= op_status;
      for (int i = 1; i < DFTS_HIST_N; i++) begin
        hist_code_r[i] <= hist_code_r[i-1];
        hist_stat_r[i] <= hist_stat_r[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt: sticky per code, write one clears, set wins
  logic cut_d_r;
  logic [15:0] ev;

  always_comb begin
    ev = '0;
    if (new_trip && !clr_req) begin
      ev[new_code] = 1'b1;
    end
    ev[DFTS_F_CUT] = cut && !cut_d_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cut_d_r <= 1'b0;
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      cut_d_r <= cut;
      if (wr_acc && paddr == DFTS_ISTA_OFF) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[15:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB writes, zero wait state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      limit_ms_r <= DFTS_LIMT_RST;
      max_freq_r <= DFTS_MAXF_RST;
      irq_mask_r <= '0;
      key_rst_r <= 1'b0;
    end else begin
      key_rst_r <= wr_acc && paddr == DFTS_CTRL_OFF && pwdata[DFTS_CTRL_RST_BIT];
      if (wr_acc && paddr == DFTS_LIMT_OFF) begin
        limit_ms_r <= pwdata[15:0];
      end
      if (wr_acc && paddr == DFTS_MAXF_OFF) begin
        max_freq_r <= pwdata[15:0];
      end
      if (wr_acc && paddr == DFTS_IMSK_OFF) begin
        irq_mask_r <= pwdata[15:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= '0;
      unique case (paddr)
        DFTS_VIEW_OFF: begin
          prdata_r[3:0] <= latched ? fault_r : (cut ? DFTS_F_CUT : DFTS_F_NONE);
          prdata_r[DFTS_VIEW_EN_BIT] <= pwr_en;
          prdata_r[DFTS_VIEW_LAT_BIT] <= latched;
        end
        DFTS_LIMT_OFF: prdata_r[15:0] <= limit_ms_r;
        DFTS_MAXF_OFF: prdata_r[15:0] <= max_freq_r;
        DFTS_ISTA_OFF: prdata_r[15:0] <= irq_stat_r;
        DFTS_IMSK_OFF: prdata_r[15:0] <= irq_mask_r;
        default: begin
          for (int i = 0; i < DFTS_HIST_N; i++) begin
            if (paddr == DFTS_HIST_OFF + 8'(4 * i)) begin
              prdata_r[3:0] <= hist_code_r[i];
              prdata_r[DFTS_STAT_LSB +: 16] <= hist_stat_r[i];
            end
          end
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_trip_seen;
    new_trip && !clr_req;
  endsequence

  a_surge_trip_code: assert property (@(posedge mclk) disable iff (!rst_n)
    (cur_pct > DFTS_SURGE_PCT && !latched && !clr_req) |=> fault_r == DFTS_F_SURGE ##1 !pwr_en)
    else $error("surge did not trip");

  a_latched_output_off: assert property (@(posedge mclk) disable iff (!rst_n)
    latched |=> !pwr_en)
    else $error("output on while latched");

  a_latch_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (latched && !clr_req) |=> (fault_r == $past(fault_r)))
    else $error("fault dropped without reset");

  a_reset_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_req |=> !latched)
    else $error("reset did not clear fault");

  a_hist_shift_in: assert property (@(posedge mclk) disable iff (!rst_n)
    s_trip_seen |=> hist_code_r[0] == $past(new_code) && hist_code_r[1] == $past(hist_code_r[0]))
    else $error("history not shifted");

  a_hist_status: assert property (@(posedge mclk) disable iff (!rst_n)
    s_trip_seen |=> hist_stat_r[0] == $past(op_status) && hist_code_r[4] == $past(hist_code_r[3]))
    else $error("history status wrong");

  a_cut_no_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (cut && !trip_any && !latched) |=> !pwr_en && !latched)
    else $error("cut-off misbehaved");

  a_speed_trip: assert property (@(posedge mclk) disable iff (!rst_n)
    ({1'b0, motor_freq} > speed_excess_trip_lim && !latched && !clr_req) |=> latched)
    else $error("overspeed missed");

  a_sust_trip: assert property (@(posedge mclk) disable iff (!rst_n)
    (sust_hit && !latched && !clr_req) |=> latched)
    else $error("sustained current missed");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 irq == $past(|(irq_stat_r & irq_mask_r)))
    else $error("irq level wrong");

endmodule

// ===== test/dfts_far_side.sv
// Far-side model: sense comparators, contacts, reset terminal, measurements.
// Assumes the bench selects one fault condition at a time by its code.
`timescale 1ns/1ps
module dfts_far_side import dfts_pkg::*; (
  input wire logic [3:0] code,
  input wire logic rst_term_closed,
  output logic [DFTS_PINS-1:0] sense_pins,
  output logic [9:0] cur_pct,
  output logic [15:0] motor_freq,
  output logic [15:0] op_status
);
  //////////////////////////////////////////////////////////////////////////
  // Pins sit at idle levels unless the selected code, or the reset terminal for its pin, drives them
  always_comb begin
    sense_pins = DFTS_PIN_IDLE;
    sense_pins[DFTS_P_LEAK] = (code == DFTS_F_LEAK);
    sense_pins[DFTS_P_DCHI] = (code == DFTS_F_DCHI);
    sense_pins[DFTS_P_DCLO] = (code == DFTS_F_DCLO);
    sense_pins[DFTS_P_LINK] = (code == DFTS_F_LINK);
    sense_pins[DFTS_P_HEAT] = (code == DFTS_F_HEAT);
    sense_pins[DFTS_P_EXTNO] = (code == DFTS_F_EXTNO);
    sense_pins[DFTS_P_EXTNC] = (code != DFTS_F_EXTNC);
    sense_pins[DFTS_P_SHORT] = (code == DFTS_F_SHORT);
    sense_pins[DFTS_P_CUT] = (code == DFTS_F_CUT);
    sense_pins[DFTS_P_RSTT] = !rst_term_closed;
    sense_pins[DFTS_P_PH + 1] = (code == DFTS_F_PHASE);
  end
  //////////////////////////////////////////////////////////////////////////
  // Measurements rest on their boundaries; a code pushes one over
  always_comb begin
    case (code)
      DFTS_F_SURGE: cur_pct = 10'h0C9;
      DFTS_F_SUST: cur_pct = DFTS_SUST_PCT;
      DFTS_F_THERM: cur_pct = DFTS_OVL_PCT;
      default: cur_pct = DFTS_RATED_PCT;
    endcase
    motor_freq = (code == DFTS_F_SPEED) ? 16'h0321 : 16'h0320;
    op_status = {12'hC00, code};
  end
endmodule

// ===== test/drive_fault_trip_supervisor_tb.sv
// Self-checking bench for the fault trip supervisor.
// Assumes zero-wait APB and a one-cycle millisecond tick.
`timescale 1ns/1ps
module drive_fault_trip_supervisor_tb import dfts_pkg::*;;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, pwr_en, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [DFTS_PINS-1:0] sense_pins;
  logic [9:0] cur_pct;
  logic [15:0] motor_freq, op_status;
  logic [3:0] code;
  logic rst_term_closed;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [3:0] seq [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB,
    4'hC, 4'hD};

  dfts_supervisor #(.TICK_CYC(1)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_pins(sense_pins), .cur_pct(cur_pct),
    .motor_freq(motor_freq), .op_status(op_status), .pwr_en(pwr_en), .irq(irq));
  dfts_far_side far_u (.code(code), .rst_term_closed(rst_term_closed),
    .sense_pins(sense_pins), .cur_pct(cur_pct), .motor_freq(motor_freq),
    .op_status(op_status));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(name, exp, rd);
  endtask
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    check("pwr_en", 32'h1, pwr_en);
    rd_chk("view", DFTS_VIEW_OFF, 32'h0000_0100);
    rd_chk("limit", DFTS_LIMT_OFF, 32'h0000_EA60);
    rd_chk("maxf", DFTS_MAXF_OFF, 32'h0000_0258);
    apb(1'b0, 8'h2C, 32'h0, rd, err);
    check("unmapped err", 32'h1, err);
    check("unmapped data", 32'h0, rd);
  endtask
  task automatic t_irq();
    code <= DFTS_F_HEAT;
    settle();
    check("irq masked", 32'h0, irq);
    rd_chk("istat", DFTS_ISTA_OFF, 32'h0000_0040);
    wr(DFTS_IMSK_OFF, 32'h0000_0040);
    repeat (3) @(posedge mclk);
    check("irq on", 32'h1, irq);
    wr(DFTS_ISTA_OFF, 32'h0000_0040);
    repeat (3) @(posedge mclk);
    check("irq cleared", 32'h0, irq);
    code <= DFTS_F_NONE;
    settle();
    wr(DFTS_CTRL_OFF, 32'h0000_0001);
    settle();
  endtask
  task automatic t_trips();
    logic [3:0] c;
    wr(DFTS_LIMT_OFF, 32'h0000_0003);
    for (int i = 0; i < 12; i++) begin
      c = seq[i];
      code <= c;
      settle();
      check("pwr_en trip", 32'h0, pwr_en);
      rd_chk("view code", DFTS_VIEW_OFF, {22'h0, 2'h2, 4'h0, c});
      rd_chk("hist0", DFTS_HIST_OFF, {8'h0, 12'hC00, c, 4'h0, c});
      code <= DFTS_F_NONE;
      settle();
      check("pwr_en held", 32'h0, pwr_en);
      if (i % 2 == 0) begin
        wr(DFTS_CTRL_OFF, 32'h0000_0001);
      end else begin
        rst_term_closed <= 1'b1;
        settle();
        rst_term_closed <= 1'b0;
      end
      settle();
      check("pwr_en back", 32'h1, pwr_en);
    end
  endtask
  task automatic t_cut_hist();
    code <= DFTS_F_CUT;
    settle();
    check("cut pwr_en", 32'h0, pwr_en);
    rd_chk("cut view", DFTS_VIEW_OFF, 32'h0000_000E);
    code <= DFTS_F_NONE;
    settle();
    check("cut release", 32'h1, pwr_en);
    for (int k = 0; k < DFTS_HIST_N; k++) begin
      rd_chk("hist", DFTS_HIST_OFF + 8'(4 * k), {8'h0, 12'hC00, seq[11 - k], 4'h0,
        seq[11 - k]});
    end
  endtask
  // Power cycle mid-run clears a latched fault and the history
  task automatic t_power_cycle();
    code <= DFTS_F_HEAT;
    settle();
    check("pc latched", 32'h0, pwr_en);
    code <= DFTS_F_NONE;
    settle();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check("pc pwr_en", 32'h1, pwr_en);
    rd_chk("pc view", DFTS_VIEW_OFF, 32'h0000_0100);
    rd_chk("pc hist0", DFTS_HIST_OFF, 32'h0000_0000);
  endtask
  task automatic t_thermal();
    code <= DFTS_F_THERM;
    repeat (59000) @(posedge mclk);
    check("therm early", 32'h1, pwr_en);
    for (int n = 0; n < 2000 && pwr_en !== 1'b0; n++) @(posedge mclk);
    check("therm trip", 32'h0, pwr_en);
    rd_chk("therm view", DFTS_VIEW_OFF, 32'h0000_0207);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code = DFTS_F_NONE;
    rst_term_closed = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    // pwr_en rises at the first edge after release; look one edge later
    repeat (2) @(posedge mclk);
    t_reset();
    t_irq();
    t_trips();
    t_cut_hist();
    t_power_cycle();
    t_thermal();
    complete_run();
  end
endmodule
